// ---- verilog/ubft_core.sv ----
/*
 ubft_core: register file, frame format control and transmit path of
 the asynchronous serial port.
 assumes: register strobes are one cycle and synchronous to clk; the
 pad logic resolves serial_out_pin from serial_out_oe.
*/
`timescale 1ns/100ps
module ubft_core (
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire logic serial_in_pin,
	output logic serial_in_en,
	output logic serial_in_data
);

	// ----------------------------------------------------------
	// declarations
	// ----------------------------------------------------------
	logic serial_global_enable; // master on/off
	logic word_length_select; // 1 = nine data bits
	logic parity_enable;
	logic parity_type_select; // 1 = odd
	logic stop_count_select; // 1 = two stop bits
	logic break_request; // stored only, no break generator
	logic transmit_ninth_bit;
	logic transmit_enable_bit;
	logic receive_enable_bit;
	logic high_speed_select;
	logic addr_detect_enable; // stored and read back only, no address detect logic here
	logic async_mode_select;
	logic [7:0] bit_rate_divisor;
	logic [8:0] serial_data_buffer; // word waiting for the shifter
	logic transmit_empty_flag;
	logic transmitter_idle_flag;

	ubft_pkg::ubft_state_t st; // transmit sequencer
	logic [8:0] transmit_shifter;
	logic [3:0] bit_cnt; // data bits already on the line
	logic stop_left; // a second stop bit is still due
	logic par_acc; // xor of data bits sent so far
	logic bit_tick;
	logic baud_run;
	logic tx_run;
	logic rx_run;
	logic tx_load;
	logic frame_done;
	logic data_wr;
	logic [3:0] nbits;
	logic [7:0] next_rdata;

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	// word length in bits from the select bit
	function automatic logic [3:0] word_bits(input logic nine);
		return nine ? ubft_pkg::BITS9 : ubft_pkg::BITS8;
	endfunction

	// address decode of a strobe
	function automatic logic hit(input logic stb, input logic [2:0] a,
			input logic [2:0] r);
		return stb && (a == r);
	endfunction

	assign nbits = word_bits(word_length_select);
	assign baud_run = serial_global_enable && async_mode_select;
	assign tx_run = baud_run && transmit_enable_bit;
	assign rx_run = baud_run && receive_enable_bit;
	// a write is refused while the buffer still holds a word
	assign data_wr = hit(reg_wr, reg_addr, ubft_pkg::REG_DATA) &&
		transmit_empty_flag;
	assign frame_done = tx_run && st == ubft_pkg::ST_STOP && bit_tick &&
		!stop_left;
	// load the shifter when idle, or straight after the last stop bit
	assign tx_load = tx_run && !transmit_empty_flag &&
		(st == ubft_pkg::ST_IDLE || frame_done);

	// ----------------------------------------------------------
	// bit-rate generator, shared by both directions
	// ----------------------------------------------------------
	ubft_baud u_baud (
		.clk(clk),
		.srst(srst),
		.run(baud_run),
		.high_speed_select(high_speed_select),
		.bit_rate_divisor(bit_rate_divisor),
		.bit_tick(bit_tick)
	);

	// ----------------------------------------------------------
	// control_one
	// ----------------------------------------------------------
	// format bits survive a global disable; only break is dropped
	always_ff @(posedge clk) begin
		if (srst) begin
			{serial_global_enable, word_length_select, parity_enable,
				parity_type_select, stop_count_select} <= 5'h00;
			break_request <= 1'b0;
			transmit_ninth_bit <= 1'b0;
		end else if (hit(reg_wr, reg_addr, ubft_pkg::REG_CTL1)) begin
			serial_global_enable <= reg_wdata[ubft_pkg::C1_GEN];
			word_length_select <= reg_wdata[ubft_pkg::C1_WLEN];
			parity_enable <= reg_wdata[ubft_pkg::C1_PEN];
			parity_type_select <= reg_wdata[ubft_pkg::C1_PTYPE];
			stop_count_select <= reg_wdata[ubft_pkg::C1_STOP2];
			break_request <= reg_wdata[ubft_pkg::C1_BRK] &&
				reg_wdata[ubft_pkg::C1_GEN];
			transmit_ninth_bit <= reg_wdata[ubft_pkg::C1_TX8];
		end else if (!serial_global_enable) begin
			break_request <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// control_two
	// ----------------------------------------------------------
	// enables cannot be set while the port is globally off
	always_ff @(posedge clk) begin
		if (srst) begin
			{transmit_enable_bit, receive_enable_bit, high_speed_select,
				addr_detect_enable} <= ubft_pkg::RST_CTL2[7:4];
		end else if (hit(reg_wr, reg_addr, ubft_pkg::REG_CTL2)) begin
			transmit_enable_bit <= reg_wdata[ubft_pkg::C2_TXEN] &&
				serial_global_enable;
			receive_enable_bit <= reg_wdata[ubft_pkg::C2_RXEN] &&
				serial_global_enable;
			high_speed_select <= reg_wdata[ubft_pkg::C2_HS];
			addr_detect_enable <= reg_wdata[ubft_pkg::C2_ADDEN];
		end else if (!serial_global_enable) begin
			transmit_enable_bit <= 1'b0;
			receive_enable_bit <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// divisor and mode select
	// ----------------------------------------------------------
	// untouched by a global disable so re-enable resumes as before
	always_ff @(posedge clk) begin
		if (srst) begin
			bit_rate_divisor <= ubft_pkg::RST_DIV;
			async_mode_select <= 1'b0;
		end else begin
			if (hit(reg_wr, reg_addr, ubft_pkg::REG_DIV)) begin
				bit_rate_divisor <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, ubft_pkg::REG_MODE)) begin
				async_mode_select <= reg_wdata[ubft_pkg::MODE_ASYNC];
			end
		end
	end

	// ----------------------------------------------------------
	// data buffer and transmit flags
	// ----------------------------------------------------------
	// the ninth bit is taken from control_one at the data write,
	// so software must set it first; the msb doubles as the
	// address mark when the far end detects addresses
	always_ff @(posedge clk) begin
		if (srst) begin
			serial_data_buffer <= 9'h000;
		end else if (data_wr) begin
			serial_data_buffer <= {transmit_ninth_bit &&
				word_length_select, reg_wdata};
		end
	end

	// empty flag: a load sets it, an accepted write clears it
	always_ff @(posedge clk) begin
		if (srst || !serial_global_enable) begin
			transmit_empty_flag <= 1'b1;
		end else if (tx_load) begin
			transmit_empty_flag <= 1'b1;
		end else if (data_wr) begin
			transmit_empty_flag <= 1'b0;
		end
	end

	// idle flag: end of frame sets it and wins over a same-cycle write
	always_ff @(posedge clk) begin
		if (srst || !serial_global_enable) begin
			transmitter_idle_flag <= 1'b1;
		end else if (frame_done) begin
			transmitter_idle_flag <= 1'b1;
		end else if (data_wr) begin
			transmitter_idle_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// transmit sequencer
	// ----------------------------------------------------------
	// a drop of global enable, async mode or transmit enable resets the shifter at once, mid-frame too
	always_ff @(posedge clk) begin
		if (srst || !tx_run) begin
			st <= ubft_pkg::ST_IDLE;
			serial_out_pin <= 1'b1;
			transmit_shifter <= 9'h000;
			bit_cnt <= 4'h0;
			stop_left <= 1'b0;
			par_acc <= 1'b0;
		end else begin
			case (st)
				ubft_pkg::ST_IDLE: begin
					serial_out_pin <= 1'b1;
					if (tx_load) begin
						transmit_shifter <= serial_data_buffer;
						st <= ubft_pkg::ST_ARMED;
					end
				end
				// wait for a bit boundary so the start bit is full width
				ubft_pkg::ST_ARMED: begin
					if (bit_tick) begin
						serial_out_pin <= 1'b0;
						st <= ubft_pkg::ST_START;
					end
				end
				ubft_pkg::ST_START, ubft_pkg::ST_DATA: begin
					if (bit_tick) begin
						if (bit_cnt == nbits) begin
							serial_out_pin <= 1'b1;
							stop_left <= stop_count_select;
							st <= ubft_pkg::ST_STOP;
						end else begin
							// parity takes the place of the last data bit
							if (parity_enable && bit_cnt == nbits - 4'h1) begin
								serial_out_pin <= par_acc ^
									parity_type_select;
							end else begin
								serial_out_pin <= transmit_shifter[0];
							end
							par_acc <= par_acc ^ transmit_shifter[0];
							transmit_shifter <= {1'b0,
								transmit_shifter[8:1]};
							bit_cnt <= bit_cnt + 4'h1;
							st <= ubft_pkg::ST_DATA;
						end
					end
				end
				ubft_pkg::ST_STOP: begin
					if (bit_tick) begin
						if (stop_left) begin
							stop_left <= 1'b0;
						end else if (tx_load) begin
							// back to back: next start bit follows at once
							transmit_shifter <= serial_data_buffer;
							serial_out_pin <= 1'b0;
							bit_cnt <= 4'h0;
							par_acc <= 1'b0;
							st <= ubft_pkg::ST_START;
						end else begin
							bit_cnt <= 4'h0;
							par_acc <= 1'b0;
							st <= ubft_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					st <= ubft_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------
	// pin ownership
	// ----------------------------------------------------------
	// pins go back to their shared functions when not fully enabled
	always_ff @(posedge clk) begin
		if (srst) begin
			serial_out_oe <= 1'b0;
			serial_in_en <= 1'b0;
			serial_in_data <= 1'b1;
		end else begin
			serial_out_oe <= tx_run;
			serial_in_en <= rx_run;
			// idle level presented while the input is not owned
			serial_in_data <= rx_run ? serial_in_pin : 1'b1;
		end
	end

	// ----------------------------------------------------------
	// register read port
	// ----------------------------------------------------------
	// the data register reads zero: receive path lives elsewhere
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ubft_pkg::REG_CTL1: begin
				next_rdata[ubft_pkg::C1_GEN] = serial_global_enable;
				next_rdata[ubft_pkg::C1_WLEN] = word_length_select;
				next_rdata[ubft_pkg::C1_PEN] = parity_enable;
				next_rdata[ubft_pkg::C1_PTYPE] = parity_type_select;
				next_rdata[ubft_pkg::C1_STOP2] = stop_count_select;
				next_rdata[ubft_pkg::C1_BRK] = break_request;
			end
			ubft_pkg::REG_CTL2: begin
				next_rdata[ubft_pkg::C2_TXEN] = transmit_enable_bit;
				next_rdata[ubft_pkg::C2_RXEN] = receive_enable_bit;
				next_rdata[ubft_pkg::C2_HS] = high_speed_select;
				next_rdata[ubft_pkg::C2_ADDEN] = addr_detect_enable;
			end
			ubft_pkg::REG_STAT: begin
				next_rdata[ubft_pkg::ST_TXE] = transmit_empty_flag;
				next_rdata[ubft_pkg::ST_TIDLE] = transmitter_idle_flag;
				next_rdata[ubft_pkg::ST_RIDLE] = 1'b1;
			end
			ubft_pkg::REG_DIV: begin
				next_rdata = bit_rate_divisor;
			end
			ubft_pkg::REG_MODE: begin
				next_rdata[ubft_pkg::MODE_ASYNC] = async_mode_select;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// read data stand one cycle only, zero otherwise
	always_ff @(posedge clk) begin
		if (srst || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// tick spacing monitor, restarted whenever the rate may change
	logic [14:0] gap;
	logic gap_ok;
	logic [14:0] exp_gap;
	assign exp_gap = (15'(bit_rate_divisor) + 15'h0001) << (high_speed_select ?
		ubft_pkg::PRE_SH_HI : ubft_pkg::PRE_SH_LO);

	always_ff @(posedge clk) begin
		if (srst || !baud_run || reg_wr) begin
			gap <= 15'h0001;
			gap_ok <= 1'b0;
		end else if (bit_tick) begin
			gap <= 15'h0001;
			gap_ok <= 1'b1;
		end else begin
			gap <= gap + 15'h0001;
		end
	end

	AST_BIT_PERIOD: assert property (
		bit_tick && gap_ok && !reg_wr |-> gap == exp_gap)
		else $error("bit tick spacing differs from divisor setting");

	AST_LINE_IDLE_HIGH: assert property (
		tx_run && st == ubft_pkg::ST_IDLE && $past(tx_run) |-> serial_out_pin)
		else $error("line not high between frames");

	AST_START_LOW: assert property (
		st == ubft_pkg::ST_ARMED && bit_tick && tx_run |=>
			!serial_out_pin && st == ubft_pkg::ST_START)
		else $error("start bit missing");

	AST_FLOAT_WHEN_OFF: assert property (
		!tx_run |=> !serial_out_oe)
		else $error("transmit pin driven while disabled");

	AST_PINS_OWNED: assert property (
		tx_run && rx_run |=> serial_out_oe && serial_in_en)
		else $error("pins not taken while fully enabled");

	AST_DISABLE_FLAGS: assert property (
		!serial_global_enable && !reg_wr [*2] |->
			transmit_empty_flag && transmitter_idle_flag &&
			!transmit_enable_bit && !receive_enable_bit && !break_request)
		else $error("flags not reset by global disable");

	AST_KEEP_DIVISOR: assert property (
		!serial_global_enable && !hit(reg_wr, reg_addr, ubft_pkg::REG_DIV) |=>
			bit_rate_divisor == $past(bit_rate_divisor))
		else $error("divisor changed without a write");

	AST_ABORT: assert property (
		$fell(tx_run) |=> st == ubft_pkg::ST_IDLE && serial_out_pin && !serial_out_oe)
		else $error("frame not abandoned on disable");

	AST_IMMEDIATE_LOAD: assert property (
		tx_run && st == ubft_pkg::ST_IDLE && !transmit_empty_flag |=>
			st == ubft_pkg::ST_ARMED && transmit_empty_flag)
		else $error("idle shifter did not take the word");

	AST_STOP_LENGTH: assert property (
		tx_run && st == ubft_pkg::ST_DATA && bit_tick && bit_cnt == nbits &&
		stop_count_select |=> stop_left && serial_out_pin)
		else $error("second stop bit not scheduled");

endmodule // ubft_core

// ---- verilog/ubft_pkg.sv ----
/*
 ubft_pkg: register offsets, field positions, reset values and divider
 constants for the serial transmitter core.
 assumes: one 50 MHz clock, a plain register port with 3-bit address.
*/
// Overview of operation
// - bit rate is fH over 64(N+1) or 16(N+1)
// - free-running 8-bit counter, divisor 0 to 255
// - start bit, 8 or 9 data, stop bits
// - even/odd/no parity, reset gives 8N1
// - least significant bit goes out first
// - tx and rx share format and rate
// - pins connected only when mode and enables set
// - line stays high between frames
// - global disable frees pins, empties buffers
// - global disable clears enables and error flags
// - global disable keeps other control and divisor; break_request is cleared here
// - global disable aborts activity at once
// - four control bits pick word format
// - data msb marks address when detection on
// - two stop bits only for the transmitter
// - shifter reloads only after stop bit left
// - send once data waits and timing runs
// - idle shifter takes written word at once
// - clearing tx enable aborts and resets transmitter
// - disabled transmitter leaves pin undriven
package ubft_pkg;

	// ----------------------------------------------------------
	// register map
	// ----------------------------------------------------------
	localparam logic [2:0] REG_CTL1 = 3'h0; // control_one
	localparam logic [2:0] REG_CTL2 = 3'h1; // control_two
	localparam logic [2:0] REG_STAT = 3'h2; // status flags
	localparam logic [2:0] REG_DATA = 3'h3; // serial_data_buffer
	localparam logic [2:0] REG_DIV = 3'h4; // bit_rate_divisor
	localparam logic [2:0] REG_MODE = 3'h5; // interface_mode_control

	// control_one fields
	localparam int C1_GEN = 7; // serial_global_enable
	localparam int C1_WLEN = 6; // word_length_select, 1 = 9 bits
	localparam int C1_PEN = 5; // parity_enable
	localparam int C1_PTYPE = 4; // parity_type_select, 1 = odd
	localparam int C1_STOP2 = 3; // stop_count_select, 1 = two
	localparam int C1_BRK = 2; // break_request
	localparam int C1_TX8 = 0; // transmit_ninth_bit

	// control_two fields
	localparam int C2_TXEN = 7; // transmit_enable_bit
	localparam int C2_RXEN = 6; // receive_enable_bit
	localparam int C2_HS = 5; // high_speed_select
	localparam int C2_ADDEN = 4; // address detect enable

	// status fields; receiver error flags read as zero here
	localparam int ST_TXE = 0; // transmit_empty_flag
	localparam int ST_TIDLE = 1; // transmitter_idle_flag
	localparam int ST_RIDLE = 2; // receiver_idle_flag

	localparam int MODE_ASYNC = 0; // async_mode_select

	// ----------------------------------------------------------
	// reset values and divider constants
	// ----------------------------------------------------------
	localparam logic [7:0] RST_CTL1 = 8'h00; // 8 data, no parity, 1 stop
	localparam logic [7:0] RST_CTL2 = 8'h00;
	localparam logic [7:0] RST_DIV = 8'h00; // reset loads zero, the fastest rate
	localparam logic [5:0] PRE_LO = 6'h3f; // 64 cycles per count
	localparam logic [5:0] PRE_HI = 6'h0f; // 16 cycles per count
	localparam int PRE_SH_LO = 6; // log2 of 64
	localparam int PRE_SH_HI = 4; // log2 of 16
	localparam logic [3:0] BITS8 = 4'h8;
	localparam logic [3:0] BITS9 = 4'h9;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ARMED, ST_START, ST_DATA, ST_STOP
	} ubft_state_t;

endpackage

// ---- verilog/ubft_baud.sv ----
/*
 ubft_baud: bit-rate generator, a prescaler of 16 or 64 followed by an
 8-bit period counter; emits a one-cycle bit tick.
 assumes: run low holds both counters cleared.
*/
`timescale 1ns/100ps
module ubft_baud (
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic high_speed_select,
	input wire logic [7:0] bit_rate_divisor,
	output logic bit_tick
);

	logic [5:0] pre_cnt; // prescale position
	logic [7:0] div_cnt; // period position
	logic pre_end; // last cycle of a prescale period
	logic div_end; // last count of the period

	// ----------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------
	// >= so a speed change mid-count cannot run past the end
	assign pre_end = pre_cnt >= (high_speed_select ?
		ubft_pkg::PRE_HI : ubft_pkg::PRE_LO);
	assign div_end = div_cnt >= bit_rate_divisor;

	// prescale counter, cleared while stopped
	always_ff @(posedge clk) begin
		if (srst || !run || pre_end) begin
			pre_cnt <= 6'h00;
		end else begin
			pre_cnt <= pre_cnt + 6'h01;
		end
	end

	// ----------------------------------------------------------
	// free-running period counter
	// ----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst || !run) begin
			div_cnt <= 8'h00;
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= pre_end && div_end;
			if (pre_end) begin
				div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
			end
		end
	end

endmodule // ubft_baud

// ---- testbench/ubft_far_end.sv ----
/*
 ubft_far_end: remote serial device on the line; takes frames mid-bit, LSB first.
 assumes: the transmit line idles high through a pull-up; period is in clocks.
*/
`timescale 1ns/100ps
module ubft_far_end (
	input wire logic clk,
	input wire logic line,
	input wire logic [15:0] period,
	input wire logic [3:0] nbits,
	input wire logic talk,
	output logic rx_pin,
	output logic [8:0] word,
	output int frames
);
	// --------------------------------------------------
	// frame receiver
	// --------------------------------------------------
	// counts a frame only when its stop bit reads high
	initial begin
		word = 9'h000;
		frames = 0;
		forever begin
			@(negedge line);
			repeat (period / 2) @(posedge clk);
			if (line === 1'b0) begin // start bit still low at mid-bit
				word = 9'h000;
				for (int i = 0; i < nbits; i++) begin
					repeat (period) @(posedge clk);
					word[i] = line; // lowest bit arrives first
				end
				repeat (period) @(posedge clk);
				if (line === 1'b1) frames++; // stop bit present
			end
		end
	end
	// --------------------------------------------------
	// line toward the core
	// --------------------------------------------------
	// idle high; a toggling pattern while talking, never a held stale level
	initial rx_pin = 1'b1;
	always @(posedge clk) rx_pin <= talk ? ~rx_pin : 1'b1;
endmodule // ubft_far_end

// ---- testbench/tb.sv ----
/*
 tb: self-checking bench of the serial transmitter core.
 assumes: register strobes driven after the rising edge; pull-up on the line.
*/
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic serial_out_pin, serial_out_oe, serial_in_pin, serial_in_en, serial_in_data;
	logic talk = 1'b0; // far end sends a pattern
	logic [15:0] period = 16'h0010; // expected bit period in clocks
	logic [3:0] nbits = 4'h8; // data bits incl. parity
	logic [8:0] word;
	int frames;
	int error_cnt = 0;
	int compares = 0;
	wire pad = serial_out_oe ? serial_out_pin : 1'b1; // released pin floats high

	always #10 clk = ~clk;

	ubft_core ubft_core_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
		.serial_in_pin(serial_in_pin), .serial_in_en(serial_in_en),
		.serial_in_data(serial_in_data));
	ubft_far_end ubft_far_end_inst (.clk(clk), .line(pad), .period(period), .nbits(nbits),
		.talk(talk), .rx_pin(serial_in_pin), .word(word), .frames(frames));

	// --------------------------------------------------
	// shared tasks
	// --------------------------------------------------
	task automatic conclude;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// a frame that never arrives ends the run instead of hanging
	task automatic wait_frames(input int n, input int lim);
		for (int i = 0; i < lim && frames < n; i++) @(posedge clk);
		if (frames < n) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, frames, n);
			conclude();
		end
	endtask
	// enables go last: they are stored only while global enable is set
	task automatic setup(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] dv);
		wr(ubft_pkg::REG_MODE, 8'h01);
		wr(ubft_pkg::REG_DIV, dv);
		wr(ubft_pkg::REG_CTL1, c1);
		wr(ubft_pkg::REG_CTL2, c2);
		period = (16'(dv) + 16'h0001) << (c2[ubft_pkg::C2_HS] ? 4 : 6);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic send(input logic [7:0] d, input logic [8:0] exp);
		int n0;
		n0 = frames;
		wr(ubft_pkg::REG_DATA, d);
		wait_frames(n0 + 1, 20 * period);
		chk(word, exp);
	endtask
	// cycles that the line spends low, starting at the next falling edge
	task automatic low_len(output int cnt);
		cnt = 0;
		for (int i = 0; i < 5000 && pad !== 1'b0; i++) begin @(posedge clk); #1; end
		for (int i = 0; i < 5000 && pad === 1'b0; i++) begin @(posedge clk); #1; cnt++; end
	endtask

	// --------------------------------------------------
	// scenarios
	// --------------------------------------------------
	task automatic t_reset;
		logic v;
		rd(ubft_pkg::REG_CTL1, 8'h00);
		rd(ubft_pkg::REG_STAT, 8'h07);
		rd(3'h6, 8'h00);
		chk(serial_out_oe, 1'b0);
		setup(8'h80, 8'h40, 8'h00); // receiver only
		chk(serial_out_oe, 1'b0);
		chk(serial_in_en, 1'b1);
		setup(8'h80, 8'he0, 8'h00);
		chk(serial_out_oe, 1'b1);
		chk(pad, 1'b1);
		talk = 1'b1;
		@(negedge clk) v = serial_in_pin;
		@(posedge clk) #1 chk(serial_in_data, v);
		talk = 1'b0;
	endtask
	task automatic t_frames;
		logic [7:0] d = 8'hd6;
		send(8'ha6, 9'h0a6);
		for (int k = 0; k < 4; k++) begin
			setup(8'ha0 | (k[0] ? 8'h10 : 8'h00) | (k[1] ? 8'h40 : 8'h00), 8'he0, 8'h00);
			nbits = k[1] ? 4'h9 : 4'h8;
			send(d, k[1] ? {^d ^ k[0], d} : {1'b0, ^d[6:0] ^ k[0], d[6:0]});
		end
		setup(8'hc9, 8'he0, 8'h00); // 9 bits, ninth bit set, two stops
		send(8'h3c, 9'h13c);
		repeat (period - 2) @(posedge clk);
		rd(ubft_pkg::REG_STAT, 8'h05);
		repeat (period) @(posedge clk);
		rd(ubft_pkg::REG_STAT, 8'h07);
	endtask
	task automatic t_b2b;
		int n0;
		setup(8'h80, 8'he0, 8'h00);
		nbits = 4'h8;
		n0 = frames;
		wr(ubft_pkg::REG_DATA, 8'h0f);
		rd(ubft_pkg::REG_STAT, 8'h05);
		wr(ubft_pkg::REG_DATA, 8'hf0);
		rd(ubft_pkg::REG_STAT, 8'h04);
		wait_frames(n0 + 1, 400);
		chk(word, 9'h00f);
		wait_frames(n0 + 2, 400);
		chk(word, 9'h0f0);
	endtask
	// slow 64x rate; word loaded while the transmitter is still off
	task automatic t_late;
		int n0;
		setup(8'h80, 8'h40, 8'h00);
		n0 = frames;
		wr(ubft_pkg::REG_DATA, 8'h3a);
		wr(ubft_pkg::REG_CTL2, 8'hc0);
		wait_frames(n0 + 1, 20 * period);
		chk(word, 9'h03a);
	endtask
	// transmitter cut in mid-word; the tail of the frame reads the pull-up
	task automatic t_abort;
		int n0, lows;
		n0 = frames;
		wr(ubft_pkg::REG_DATA, 8'h0f);
		low_len(lows);
		chk(lows, period);
		repeat (2 * period) @(posedge clk);
		wr(ubft_pkg::REG_CTL2, 8'h40);
		repeat (2) @(posedge clk);
		#1 chk(serial_out_oe, 1'b0);
		wait_frames(n0 + 1, 20 * period);
		chk(word, 9'h0ff);
		wr(ubft_pkg::REG_CTL2, 8'hc0);
		lows = 0;
		repeat (3 * period) @(posedge clk) lows += (pad !== 1'b1);
		chk(lows, 0);
		send(8'h5a, 9'h05a);
	endtask
	// slowest high-speed rate, then global disable in mid-frame
	task automatic t_off;
		int n0, cnt;
		// let the last stop bit end at the old rate, so both words are taken
		repeat (period) @(posedge clk);
		setup(8'h88, 8'he0, 8'hff);
		n0 = frames;
		wr(ubft_pkg::REG_DATA, 8'h01);
		wr(ubft_pkg::REG_DATA, 8'h55);
		low_len(cnt);
		chk(cnt, 16'h1000);
		wr(ubft_pkg::REG_CTL1, 8'h08);
		repeat (2) @(posedge clk);
		#1 chk({serial_out_oe, serial_in_en}, 2'b00);
		rd(ubft_pkg::REG_CTL1, 8'h08);
		rd(ubft_pkg::REG_CTL2, 8'h20);
		rd(ubft_pkg::REG_STAT, 8'h07);
		rd(ubft_pkg::REG_DIV, 8'hff);
		setup(8'h88, 8'he0, 8'h00);
		cnt = 0;
		repeat (64) @(posedge clk) cnt += (pad !== 1'b1);
		chk(cnt, 0);
		wait_frames(n0 + 1, 50000);
		send(8'h81, 9'h081);
	endtask

	// --------------------------------------------------
	// main sequence
	// --------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_frames();
		t_b2b();
		t_late();
		t_abort();
		t_off();
		conclude();
	end
endmodule // tb
